// file: rtl/channel_picker.sv
// Finds the lowest set channel at or above a starting index.
// Purely combinational; the core chooses mask and start index.
`default_nettype none
module channel_picker (
  seq_link_if.pick_end link
);
  import sar_seq_pkg::*;

  always_comb
  begin
    link.pick_found = 1'b0;
    link.pick_chan = '0;
    for (int i = NUM_CH - 1; i >= 0; i--)
    begin
      if (link.pick_mask[i] && (CH_W'(i) >= link.pick_from))
      begin
        link.pick_found = 1'b1;
        link.pick_chan = CH_W'(i);
      end
    end
  end
endmodule
`default_nettype wire

// file: rtl/sar_adc_trigger_sequencer.sv
// Control core of the successive-approximation converter: registers, start logic and channel scan.
// Assumes the analog converter answers each start with a one-cycle done and its result on this clock.
`default_nettype none
module sar_adc_trigger_sequencer #(
  parameter int RES_W = 10
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rstn_in,
  // Register port
  input wire logic [sar_seq_pkg::ADDR_W-1:0] addr_in,
  input wire logic [sar_seq_pkg::DATA_W-1:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [sar_seq_pkg::DATA_W-1:0] rdata_out,
  // Trigger sources
  input wire logic [sar_seq_pkg::NUM_TIMER-1:0] timer_irq_request_in,
  input wire logic [sar_seq_pkg::NUM_MFT-1:0] multifunction_timer_trigger_in,
  // Analog converter
  output logic conv_start_out,
  output logic [sar_seq_pkg::CH_W-1:0] conv_channel_out,
  output logic conv_touch_out,
  output logic [sar_seq_pkg::DATA_W-1:0] conv_timing_out,
  output logic conv_clock_select_out,
  output logic [sar_seq_pkg::DIV_W-1:0] conv_divider_out,
  input wire logic conv_done_in,
  input wire logic [RES_W-1:0] conv_result_in,
  // Status
  output logic scan_done_irq_out,
  output logic conversion_run_out
);
  import sar_seq_pkg::*;

  seq_link_if link ();

  trigger_select u_trig (
    .clk_in(clk_in),
    .rstn_in(rstn_in),
    .timer_irq_request_in(timer_irq_request_in),
    .multifunction_timer_trigger_in(multifunction_timer_trigger_in),
    .link(link.trig_end)
  );

  channel_picker u_pick (
    .link(link.pick_end)
  );

  scan_state_e state_r, state_nxt;
  logic [7:0] ctrl0_r, ctrl0_nxt;
  logic [DATA_W-1:0] trig_r, trig_nxt, timing_r, timing_nxt, rdata_r, rdata_nxt;
  logic [NUM_CH-1:0] enable_r, enable_nxt, touch_r, touch_nxt, mask_r, mask_nxt;
  logic [CH_W-1:0] cur_r, cur_nxt;
  logic run_r, run_nxt, irq_r, irq_nxt, start_r, start_nxt, tcap_r, tcap_nxt;
  logic [RES_W-1:0] res_r [NUM_CH];
  logic [RES_W-1:0] res_nxt [NUM_CH];

  logic start_mode, repeat_on, touch_mode, wr_ctrl1, sw_start, sw_stop, trig_start;
  logic [NUM_CH-1:0] live_mask;

  function automatic logic [DATA_W-1:0] read_word(input logic [ADDR_W-1:0] a,
      input logic [7:0] c0, input logic run, input logic [NUM_CH-1:0] en, input logic [NUM_CH-1:0] tc,
      input logic [DATA_W-1:0] tg, input logic [DATA_W-1:0] tm, input logic [RES_W-1:0] rs [NUM_CH]);
    read_word = '0;
    unique case (a)
      OFS_CTRL0: read_word = DATA_W'(c0);
      OFS_CTRL1: read_word = DATA_W'(run);
      OFS_ENABLE: read_word = DATA_W'(en);
      OFS_TOUCH: read_word = DATA_W'(tc);
      OFS_TRIG: read_word = tg;
      OFS_TIMING: read_word = tm;
      default:
      begin
        for (int i = 0; i < NUM_CH; i++)
        begin
          if (a == OFS_RESULT0 + ADDR_W'(i) * OFS_RESULT_STEP)
            read_word = DATA_W'(rs[i]);
        end
      end
    endcase
  endfunction

  assign start_mode = trig_r[TRIG_MODE_BIT];
  assign repeat_on = ctrl0_r[CTRL0_REPEAT_BIT];
  assign touch_mode = ctrl0_r[CTRL0_TOUCH_BIT];
  assign wr_ctrl1 = wr_in && (addr_in == OFS_CTRL1);
  assign sw_start = !start_mode && wr_ctrl1 && wdata_in[CTRL1_RUN_BIT] && !run_r;
  assign sw_stop = !start_mode && wr_ctrl1 && !wdata_in[CTRL1_RUN_BIT] && run_r;
  // A trigger that meets a set run bit is dropped, never held over for the next idle cycle.
  assign trig_start = start_mode && link.trig_pulse && !run_r;
  // Touch-marked channels convert only in touch mode, unmarked ones only outside it.
  assign live_mask = enable_r & (touch_mode ? touch_r : ~touch_r);

  assign link.trig_code = trig_r[TRIG_SRC_LSB +: SRC_W];
  assign link.pick_mask = ((state_r == ST_IDLE) || (state_r == ST_RESCAN)) ? live_mask : mask_r;
  // While waiting, the search starts one above the channel in flight, so the order can only rise.
  assign link.pick_from = (state_r == ST_WAIT) ? cur_r + 4'h1 : '0;

  always_comb
  begin
    ctrl0_nxt = ctrl0_r;
    enable_nxt = enable_r;
    touch_nxt = touch_r;
    trig_nxt = trig_r;
    timing_nxt = timing_r;
    if (wr_in)
    begin
      unique case (addr_in)
        OFS_CTRL0: ctrl0_nxt = wdata_in[7:0];
        OFS_ENABLE: enable_nxt = wdata_in[NUM_CH-1:0];
        OFS_TOUCH: touch_nxt = wdata_in[NUM_CH-1:0];
        OFS_TRIG: trig_nxt = {3'h0, wdata_in[TRIG_SRC_LSB +: SRC_W], 7'h00, wdata_in[TRIG_MODE_BIT]};
        OFS_TIMING: timing_nxt = wdata_in;
        default: ;
      endcase
    end
    // Read data fall back to zero outside the answer cycle, so a stale word is never taken.
    rdata_nxt = rd_in ? read_word(addr_in, ctrl0_r, run_r, enable_r, touch_r, trig_r, timing_r, res_r) : '0;
  end

  always_comb
  begin
    state_nxt = state_r;
    run_nxt = run_r;
    mask_nxt = mask_r;
    cur_nxt = cur_r;
    tcap_nxt = tcap_r;
    irq_nxt = 1'b0;
    res_nxt = res_r;
    unique case (state_r)
      ST_IDLE, ST_RESCAN:
      begin
        if ((state_r == ST_RESCAN) || sw_start || trig_start)
        begin
          run_nxt = 1'b1;
          mask_nxt = live_mask;
          tcap_nxt = touch_mode;
          cur_nxt = link.pick_chan;
          // An empty selection leaves the scan stuck with run set and no interrupt.
          state_nxt = link.pick_found ? ST_ISSUE : ST_HUNG;
        end
      end
      // The converter is told to start during the single cycle spent here.
      ST_ISSUE: state_nxt = ST_WAIT;
      ST_WAIT:
      begin
        if (conv_done_in)
        begin
          res_nxt[cur_r] = conv_result_in;
          if (link.pick_found)
          begin
            cur_nxt = link.pick_chan;
            state_nxt = ST_ISSUE;
          end
          else
          begin
            irq_nxt = 1'b1;
            if (repeat_on && !start_mode)
              state_nxt = ST_RESCAN;
            else
            begin
              run_nxt = 1'b0;
              state_nxt = ST_IDLE;
            end
          end
        end
      end
      ST_HUNG: state_nxt = ST_HUNG;
      default: state_nxt = ST_IDLE;
    endcase
    // A stop abandons any conversion in flight; its result, if arriving now, is still kept.
    if (sw_stop)
    begin
      run_nxt = 1'b0;
      state_nxt = ST_IDLE;
    end
    // Registered beside the state, so the start pulse stands exactly as long as the issue state.
    start_nxt = (state_nxt == ST_ISSUE);
  end

  always_ff @(posedge clk_in)
  begin
    if (!rstn_in)
    begin
      state_r <= ST_IDLE;
      ctrl0_r <= CTRL0_RESET;
      enable_r <= CH_RESET;
      touch_r <= CH_RESET;
      mask_r <= CH_RESET;
      trig_r <= TRIG_RESET;
      timing_r <= TIMING_RESET;
      rdata_r <= '0;
      cur_r <= '0;
      run_r <= 1'b0;
      irq_r <= 1'b0;
      start_r <= 1'b0;
      tcap_r <= 1'b0;
      for (int i = 0; i < NUM_CH; i++)
        res_r[i] <= '0;
    end
    else
    begin
      state_r <= state_nxt;
      ctrl0_r <= ctrl0_nxt;
      enable_r <= enable_nxt;
      touch_r <= touch_nxt;
      mask_r <= mask_nxt;
      trig_r <= trig_nxt;
      timing_r <= timing_nxt;
      rdata_r <= rdata_nxt;
      cur_r <= cur_nxt;
      run_r <= run_nxt;
      irq_r <= irq_nxt;
      start_r <= start_nxt;
      tcap_r <= tcap_nxt;
      res_r <= res_nxt;
    end
  end

  assign rdata_out = rdata_r;
  assign conv_start_out = start_r;
  assign conv_channel_out = cur_r;
  assign conv_touch_out = tcap_r;
  assign conv_timing_out = timing_r;
  assign conv_clock_select_out = ctrl0_r[CTRL0_CLKSEL_BIT];
  assign conv_divider_out = ctrl0_r[CTRL0_DIV_LSB +: DIV_W];
  assign scan_done_irq_out = irq_r;
  assign conversion_run_out = run_r;

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rstn_in);

  // Starting and stopping.
  a_sw_start_run: assert property (sw_start |=> run_r && (start_r || state_r == ST_HUNG))
    else $error("software start did not raise run and issue a conversion");

  a_trig_start_run: assert property (trig_start && !wr_in |=> run_r)
    else $error("trigger event in trigger mode did not start a scan");

  a_idle_no_run: assert property (!run_r && !sw_start && !trig_start |=> !run_r)
    else $error("run rose without a start request");

  a_sw_blocked: assert property (start_mode && !run_r && wr_ctrl1 && !link.trig_pulse |=> !run_r)
    else $error("software write changed run in trigger mode");

  a_trig_ignored: assert property (run_r && link.trig_pulse && state_r == ST_WAIT
                                   && !conv_done_in && !sw_stop |=> state_r == ST_WAIT && $stable(cur_r))
    else $error("trigger disturbed a running scan");

  a_stop_clears: assert property (sw_stop |=> !run_r && state_r == ST_IDLE && !start_r)
    else $error("software stop left the scan running");

  // Scan progress.
  a_start_pulse: assert property (start_r |=> !start_r)
    else $error("conversion start longer than one cycle");

  a_scan_order: assert property (state_r == ST_ISSUE && $past(state_r) == ST_WAIT |-> cur_r > $past(cur_r))
    else $error("channels not converted in ascending order");

  a_chan_captured: assert property (start_r |-> mask_r[cur_r] ##1 $stable(mask_r))
    else $error("converted channel not in captured selection");

  a_capture_mask: assert property (sw_start || trig_start |=> mask_r == $past(live_mask))
    else $error("scan start did not capture the live selection");

  a_touch_capture: assert property (start_r && $past(state_r) != ST_WAIT |-> tcap_r == $past(touch_mode))
    else $error("touch mode not captured at scan start");

  a_result_kept: assert property (state_r == ST_WAIT && conv_done_in |=> res_r[$past(cur_r)] == $past(conv_result_in))
    else $error("result not stored in its channel register");

  // Scan end.
  a_done_clears: assert property (state_r == ST_WAIT && conv_done_in && !link.pick_found && !sw_stop
                                  && (!repeat_on || start_mode) |=> irq_r && !run_r ##1 !irq_r)
    else $error("single scan end did not pulse interrupt and clear run");

  a_repeat_keeps: assert property (state_r == ST_WAIT && conv_done_in && !link.pick_found && !sw_stop
                                   && repeat_on && !start_mode |=> irq_r && run_r ##1 (run_r || $past(sw_stop)))
    else $error("repeat scan dropped the run bit");

  a_rescan_mode: assert property (state_r == ST_RESCAN |-> run_r && $past(repeat_on) && !$past(start_mode))
    else $error("rescan entered outside normal repeat mode");

  a_irq_pulse: assert property (irq_r |=> !irq_r)
    else $error("done interrupt longer than one cycle");

  a_irq_needs_run: assert property (irq_r |-> $past(run_r))
    else $error("done interrupt without a running scan");

  a_empty_hang: assert property (state_r == ST_HUNG |-> run_r && !irq_r && !start_r)
    else $error("empty selection produced activity");

  a_hang_holds: assert property (state_r == ST_HUNG && !sw_stop |=> state_r == ST_HUNG && run_r)
    else $error("empty-selection scan left its stuck state");

  // Main scenarios that the bench is expected to reach.
  c_trig_scan: cover property (trig_start ##[1:200] irq_r);
  c_repeat_scan: cover property (state_r == ST_RESCAN ##[1:200] start_r);
  c_empty_start: cover property (sw_start ##1 state_r == ST_HUNG);
  c_touch_scan: cover property (start_r && tcap_r);
  c_stop_scan: cover property (sw_stop && state_r != ST_HUNG);
endmodule
`default_nettype wire

// file: rtl/sar_seq_pkg.sv
// Constants shared by the converter trigger sequencer, its trigger selector and its channel picker.
// Assumes a single 200 MHz clock domain and a plain address/strobe register port.
// Function
// - Normal mode: a scan starts only when software writes 1 to the run bit.
// - Trigger mode: the selected trigger event sets the run bit and starts a scan.
// - Triggers during a running scan are ignored; that scan continues unaffected.
// - Trigger mode: software run writes and repeat scanning never drive the run bit.
// - Source field bits 12:8; codes 0-7 timer requests, 16-19 multifunction timer triggers.
// - Any other source code means no trigger event ever starts a conversion.
// - Timer requests are taken raw, regardless of interrupt enable settings.
// - Channel converts non-touch if enabled and untouched, touch if all three set; the core converts untouched channels only with touch mode off.
// - Starting with no channel enabled gives no done interrupt; run stays 1.
// - Enabled channels convert one after another in ascending channel order.
// - Each result goes to its channel register; done interrupt follows highest channel.
// - Channel selection is captured at scan start and held until the done interrupt.
// - Without repeat, or in trigger mode, run clears when the scan finishes.
// - With repeat in normal mode, scanning continues until software clears run.
`default_nettype none
package sar_seq_pkg;
  localparam int ADDR_W = 16;
  localparam int DATA_W = 16;
  localparam int NUM_CH = 12;
  localparam int CH_W = 4;
  localparam int NUM_TIMER = 8;
  localparam int NUM_MFT = 4;
  localparam int NUM_SRC = NUM_TIMER + NUM_MFT;
  localparam int SRC_W = 5;
  localparam int DIV_W = 2;

  localparam logic [ADDR_W-1:0] OFS_CTRL0 = 16'hF840;
  localparam logic [ADDR_W-1:0] OFS_CTRL1 = 16'hF841;
  localparam logic [ADDR_W-1:0] OFS_ENABLE = 16'hF842;
  localparam logic [ADDR_W-1:0] OFS_TOUCH = 16'hF844;
  localparam logic [ADDR_W-1:0] OFS_TRIG = 16'hF846;
  localparam logic [ADDR_W-1:0] OFS_TIMING = 16'hF848;
  localparam logic [ADDR_W-1:0] OFS_RESULT0 = 16'hF850;
  localparam logic [ADDR_W-1:0] OFS_RESULT_STEP = 16'h0002;

  localparam int CTRL0_REPEAT_BIT = 0;
  localparam int CTRL0_CLKSEL_BIT = 1;
  localparam int CTRL0_TOUCH_BIT = 2;
  localparam int CTRL0_DIV_LSB = 4;
  localparam int CTRL1_RUN_BIT = 0;
  localparam int TRIG_MODE_BIT = 0;
  localparam int TRIG_SRC_LSB = 8;

  localparam logic [7:0] CTRL0_RESET = 8'h22;
  localparam logic [DATA_W-1:0] TRIG_RESET = 16'h0000;
  localparam logic [DATA_W-1:0] TIMING_RESET = 16'hFFFF;
  localparam logic [NUM_CH-1:0] CH_RESET = 12'h000;

  localparam logic [SRC_W-1:0] SRC_TIMER_LAST = 5'h07;
  localparam logic [SRC_W-1:0] SRC_MFT_FIRST = 5'h10;
  localparam logic [SRC_W-1:0] SRC_MFT_LAST = 5'h13;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ISSUE = 3'b001,
    ST_WAIT = 3'b010,
    ST_RESCAN = 3'b011,
    ST_HUNG = 3'b100
  } scan_state_e;
endpackage
`default_nettype wire

// file: rtl/seq_link_if.sv
// Links the sequencer core with its trigger selector and its channel picker.
// Assumes all three parties sit on the same clock.
`default_nettype none
interface seq_link_if;
  import sar_seq_pkg::*;
  logic trig_pulse;
  logic [SRC_W-1:0] trig_code;
  logic [NUM_CH-1:0] pick_mask;
  logic [CH_W-1:0] pick_from;
  logic [CH_W-1:0] pick_chan;
  logic pick_found;
  modport trig_end (input trig_code, output trig_pulse);
  modport pick_end (input pick_mask, input pick_from, output pick_chan, output pick_found);
  modport core_end (output trig_code, output pick_mask, output pick_from,
                    input trig_pulse, input pick_chan, input pick_found);
endinterface
`default_nettype wire

// file: rtl/trigger_select.sv
// Synchronises the timer request and multifunction timer trigger lines and picks one by code.
// Assumes the sources may come from another timing domain, so each passes two flip-flops.
`default_nettype none
module trigger_select (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rstn_in,
  // Trigger sources
  input wire logic [sar_seq_pkg::NUM_TIMER-1:0] timer_irq_request_in,
  input wire logic [sar_seq_pkg::NUM_MFT-1:0] multifunction_timer_trigger_in,
  // Core side
  seq_link_if.trig_end link
);
  import sar_seq_pkg::*;

  logic [NUM_SRC-1:0] meta_r, sync_r, prev_r;
  logic [NUM_SRC-1:0] meta_nxt, sync_nxt, prev_nxt;
  logic pulse_r, pulse_nxt;

  function automatic logic code_ok(input logic [SRC_W-1:0] code);
    code_ok = (code <= SRC_TIMER_LAST) || ((code >= SRC_MFT_FIRST) && (code <= SRC_MFT_LAST));
  endfunction

  function automatic logic [CH_W-1:0] code_index(input logic [SRC_W-1:0] code);
    if (code <= SRC_TIMER_LAST)
      code_index = CH_W'(code);
    else
      code_index = CH_W'(code - SRC_MFT_FIRST + SRC_W'(NUM_TIMER));
  endfunction

  // Raw request lines are used, never the masked interrupt flags.
  always_comb
  begin
    meta_nxt = {multifunction_timer_trigger_in, timer_irq_request_in};
    sync_nxt = meta_r;
    prev_nxt = sync_r;
    // Edges are found per source before the mux, so switching the code cannot fake an event.
    pulse_nxt = code_ok(link.trig_code) && sync_r[code_index(link.trig_code)]
                && !prev_r[code_index(link.trig_code)];
  end

  always_ff @(posedge clk_in)
  begin
    if (!rstn_in)
    begin
      meta_r <= '0;
      sync_r <= '0;
      prev_r <= '0;
      pulse_r <= 1'b0;
    end
    else
    begin
      meta_r <= meta_nxt;
      sync_r <= sync_nxt;
      prev_r <= prev_nxt;
      pulse_r <= pulse_nxt;
    end
  end

  assign link.trig_pulse = pulse_r;

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rstn_in);

  a_bad_code_quiet: assert property (!code_ok(link.trig_code) && $stable(link.trig_code) |=> !pulse_r)
    else $error("trigger pulse on a prohibited source code");
  a_pulse_single: assert property (pulse_r |=> !pulse_r)
    else $error("trigger pulse longer than one cycle");
endmodule
`default_nettype wire

// file: test/analog_conv_model.sv
// Behavioural analog converter that answers each start pulse with a one-cycle done and a result.
// Assumes the sequencer and this model share one clock and a synchronous active-low reset.
`default_nettype none
module analog_conv_model #(
  parameter int RES_W = 10
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rstn_in,
  // Sequencer side
  input wire logic start_in,
  input wire logic [3:0] channel_in,
  input wire logic slow_in,
  output logic done_out,
  output logic [RES_W-1:0] result_out
);
  timeunit 1ns;
  timeprecision 1ps;
  int wait_cnt;
  logic [3:0] chan_r;
  // The result bus toggles outside done, so a sequencer that samples it late stores garbage.
  always @(posedge clk_in)
  begin
    done_out <= 1'b0;
    result_out <= ~result_out;
    if (!rstn_in)
    begin
      wait_cnt = 0;
      result_out <= '0;
    end
    else if (start_in)
    begin
      chan_r <= channel_in;
      wait_cnt = slow_in ? 6 : 1;
    end
    else if (wait_cnt > 0)
    begin
      wait_cnt = wait_cnt - 1;
      if (wait_cnt == 0)
      begin
        done_out <= 1'b1;
        result_out <= RES_W'({chan_r, 6'h15});
      end
    end
  end
endmodule
`default_nettype wire

// file: test/sar_adc_trigger_sequencer_tb.sv
// Self-checking bench for the converter sequencer: register port, normal, repeat and trigger scans.
// Assumes the analog side is the behavioural model and all requests follow the register port contract.
`default_nettype none
module sar_adc_trigger_sequencer_tb;
  import sar_seq_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {string nm; logic [15:0] v;} note_s;
  logic clk_in, rstn_in, wr_in, rd_in, slow, rd_seen;
  logic [15:0] addr_in, wdata_in, rdata_out, conv_timing_out;
  logic [7:0] timer_irq_request_in;
  logic [3:0] multifunction_timer_trigger_in, conv_channel_out;
  logic conv_start_out, conv_touch_out, conv_clock_select_out, conv_done_in, scan_done_irq_out, conversion_run_out;
  logic [1:0] conv_divider_out;
  logic [9:0] conv_result_in;
  note_s rd_q[$], ch_q[$], n;
  int fail_count = 0, num_checks = 0, irq_cnt = 0, cyc = 0, k;
  int codes[12] = '{0, 1, 2, 3, 4, 5, 6, 7, 16, 17, 18, 19};
  int bad[4] = '{8, 15, 20, 31};

  sar_adc_trigger_sequencer #(.RES_W(10)) u_dut (.clk_in(clk_in), .rstn_in(rstn_in), .addr_in(addr_in),
    .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
    .timer_irq_request_in(timer_irq_request_in), .multifunction_timer_trigger_in(multifunction_timer_trigger_in),
    .conv_start_out(conv_start_out), .conv_channel_out(conv_channel_out), .conv_touch_out(conv_touch_out),
    .conv_timing_out(conv_timing_out), .conv_clock_select_out(conv_clock_select_out),
    .conv_divider_out(conv_divider_out), .conv_done_in(conv_done_in), .conv_result_in(conv_result_in),
    .scan_done_irq_out(scan_done_irq_out), .conversion_run_out(conversion_run_out));
  analog_conv_model #(.RES_W(10)) u_model (.clk_in(clk_in), .rstn_in(rstn_in), .start_in(conv_start_out),
    .channel_in(conv_channel_out), .slow_in(slow), .done_out(conv_done_in), .result_out(conv_result_in));

  always #2.5 clk_in = ~clk_in;

  task automatic stop_test();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= 1'b1;
    @(posedge clk_in);
    wr_in <= 1'b0;
    @(posedge clk_in);
  endtask

  task automatic rd(input logic [15:0] a, input logic [15:0] exp, input string nm);
    rd_q.push_back('{nm, exp});
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge clk_in);
    rd_in <= 1'b0;
    @(posedge clk_in);
  endtask

  // A source is a level; the sequencer reacts to its rising edge only.
  task automatic pulse(input int src);
    if (src < 8)
      timer_irq_request_in[src] <= 1'b1;
    else if (src >= 16 && src < 20)
      multifunction_timer_trigger_in[src-16] <= 1'b1;
    else
    begin
      timer_irq_request_in <= 8'hFF;
      multifunction_timer_trigger_in <= 4'hF;
    end
    repeat (4) @(posedge clk_in);
    timer_irq_request_in <= 8'h00;
    multifunction_timer_trigger_in <= 4'h0;
    @(posedge clk_in);
  endtask

  task automatic wait_run(input logic v);
    int i;
    for (i = 0; i < 400 && conversion_run_out !== v; i++)
      @(posedge clk_in);
    check("run wait", 16'(conversion_run_out), 16'(v));
  endtask

  task automatic scan(input logic [11:0] en, input logic [11:0] tc, input logic tm, input logic trig, input int src);
    logic [11:0] m;
    int i0;
    m = en & (tm ? tc : ~tc);
    for (k = 0; k < 12; k++)
      if (m[k])
        ch_q.push_back('{"scan channel", {11'h000, tm, 4'(k)}});
    wr(OFS_CTRL0, tm ? 16'h0026 : 16'h0022);
    wr(OFS_TIMING, tm ? 16'hAB78 : 16'h0378);
    check("timing out", conv_timing_out, tm ? 16'hAB78 : 16'h0378);
    wr(OFS_ENABLE, {4'h0, en});
    wr(OFS_TOUCH, {4'h0, tc});
    i0 = irq_cnt;
    if (trig)
    begin
      wr(OFS_TRIG, {3'b000, 5'(src), 8'h00});
      wr(OFS_TRIG, {3'b000, 5'(src), 8'h01});
      check("run after arming", 16'(conversion_run_out), 16'h0000);
      pulse(src);
      wait_run(1'b1);
      pulse(src);
      wr(OFS_CTRL1, 16'h0000);
    end
    else
    begin
      wr(OFS_CTRL1, 16'h0001);
    end
    wr(OFS_ENABLE, {4'h0, ~en});
    wait_run(1'b0);
    repeat (10) @(posedge clk_in);
    check("scan irq count", 16'(irq_cnt - i0), 16'h0001);
    for (k = 0; k < 12; k++)
      if (m[k])
        rd(OFS_RESULT0 + 16'(2 * k), {6'h00, 4'(k), 6'h15}, "channel result");
    check("pending starts", 16'(ch_q.size()), 16'h0000);
    wr(OFS_TRIG, 16'h0000);
  endtask

  always @(posedge clk_in)
  begin
    rd_seen <= rd_in;
    cyc++;
    if (cyc == 40000)
    begin
      fail_count++;
      stop_test();
    end
  end

  always @(negedge clk_in)
  begin
    if (rd_seen === 1'b1)
    begin
      n = rd_q.pop_front();
      check(n.nm, rdata_out, n.v);
    end
    if (conv_start_out === 1'b1)
    begin
      if (ch_q.size() > 0)
      begin
        n = ch_q.pop_front();
        check(n.nm, {11'h000, conv_touch_out, conv_channel_out}, n.v);
      end
      else
        check("unexpected start", 16'h0001, 16'h0000);
    end
    if (scan_done_irq_out === 1'b1)
      irq_cnt++;
  end

  initial
  begin
    clk_in = 1'b0;
    rstn_in = 1'b0;
    addr_in = 16'h0000;
    wdata_in = 16'h0000;
    wr_in = 1'b0;
    rd_in = 1'b0;
    slow = 1'b1;
    timer_irq_request_in = 8'h00;
    multifunction_timer_trigger_in = 4'h0;
    void'($urandom(32'hBBB6));
    repeat (8) @(posedge clk_in);
    rstn_in <= 1'b1;
    @(posedge clk_in);
    check("clock fields", 16'({conv_clock_select_out, conv_divider_out}), 16'h0006);
    rd(OFS_TRIG, 16'h0000, "trigger reset");
    rd(OFS_TIMING, 16'hFFFF, "timing reset");
    rd(OFS_CTRL1, 16'h0000, "control1 reset");
    rd(16'hF84E, 16'h0000, "unmapped read");
    wdata_in <= 16'($urandom);
    wr(OFS_TRIG, 16'hFFFE);
    rd(OFS_TRIG, 16'h1F00, "trigger field");
    wr(16'hF84E, 16'hFFFF);
    rd(16'hF84E, 16'h0000, "unmapped write");
    wr(OFS_CTRL0, 16'h0010);
    check("clock fields", 16'({conv_clock_select_out, conv_divider_out}), 16'h0001);
    rd(OFS_CTRL0, 16'h0010, "control0 field");
    wr(OFS_TRIG, 16'h0000);
    $display("test registers finished");
    for (int t = 0; t < 4; t++)
    begin
      slow <= 1'($urandom);
      scan(12'($urandom) | 12'h801, 12'($urandom) & 12'h7FE, 1'b0, 1'b0, 0);
      scan(12'($urandom) | 12'h801, 12'($urandom) | 12'h801, 1'b1, 1'b0, 0);
    end
    $display("test normal scans finished");
    slow <= 1'b1;
    foreach (codes[i])
      scan(12'($urandom) | 12'h801, 12'h000, 1'b0, 1'b1, codes[i]);
    $display("test trigger scans finished");
    foreach (bad[i])
    begin
      wr(OFS_TRIG, {3'b000, 5'(bad[i]), 8'h01});
      pulse(bad[i]);
      wr(OFS_CTRL1, 16'h0001);
      rd(OFS_CTRL1, 16'h0000, "prohibited source run");
    end
    wr(OFS_TRIG, 16'h0000);
    $display("test prohibited sources finished");
    k = irq_cnt;
    // Three passes are noted: the stop lands just after the third pass issues its first channel.
    for (int c = 0; c < 36; c++)
      ch_q.push_back('{"repeat channel", {12'h000, 4'(c % 12)}});
    wr(OFS_ENABLE, 16'h0FFF);
    wr(OFS_CTRL0, 16'h0023);
    wr(OFS_CTRL1, 16'h0001);
    for (int i = 0; i < 1000 && irq_cnt < k + 2; i++)
      @(posedge clk_in);
    wr(OFS_CTRL1, 16'h0000);
    ch_q.delete();
    repeat (30) @(posedge clk_in);
    check("repeat irq count", 16'(irq_cnt - k), 16'h0002);
    rd(OFS_CTRL1, 16'h0000, "repeat stopped");
    $display("test repeat finished");
    wr(OFS_CTRL0, 16'h0022);
    wr(OFS_ENABLE, 16'h0000);
    k = irq_cnt;
    wr(OFS_CTRL1, 16'h0001);
    repeat (30) @(posedge clk_in);
    rd(OFS_CTRL1, 16'h0001, "empty mask run");
    check("empty mask irq", 16'(irq_cnt - k), 16'h0000);
    wr(OFS_CTRL1, 16'h0000);
    rd(OFS_CTRL1, 16'h0000, "empty mask stop");
    $display("test empty mask finished");
    repeat (4) @(posedge clk_in);
    stop_test();
  end
endmodule
`default_nettype wire
